// *** design/scpc_map.svh ***
// constants of the single-pin command interpreter
`ifndef SCPC_MAP_SVH
`define SCPC_MAP_SVH
// interface locations (low nibble of a command byte)
`define SCPC_LOC_DHR0     4'h0
`define SCPC_LOC_DHR1     4'h1
`define SCPC_LOC_DHR2     4'h2
`define SCPC_LOC_DHR3     4'h3
`define SCPC_LOC_CALSEL   4'h6
`define SCPC_LOC_EEMID    4'h7
`define SCPC_LOC_EEHI     4'h8
`define SCPC_LOC_CTRL     4'h9
`define SCPC_LOC_WIN      4'ha
`define SCPC_LOC_ASEL     4'hb
// control codes (upper nibble with location 9)
`define SCPC_CC_CALLOAD   4'h0
`define SCPC_CC_EEWRITE   4'h1
`define SCPC_CC_ERASE     4'h2
`define SCPC_CC_CALREAD   4'h3
`define SCPC_CC_EEREAD    4'h4
`define SCPC_CC_READBACK  4'h5
`define SCPC_CC_ANALOG    4'h6
`define SCPC_CC_PAGECLR   4'h7
// special bytes
`define SCPC_BYTE_REINIT  8'hff
`define SCPC_BYTE_LINK    8'hca
// readback pointer codes
`define SCPC_RP_DLO       4'h0
`define SCPC_RP_DHI       4'h1
`define SCPC_RP_EECAL     4'h2
`define SCPC_RP_CTRLPTR   4'h3
`define SCPC_RP_ANA       4'h4
`define SCPC_RP_EEADDR    4'h5
`define SCPC_RP_EEDATA    4'h6
`define SCPC_RP_TEMP      4'h7
`define SCPC_RP_BITCLK    4'h8
`define SCPC_RP_FIRSTCA   4'ha
// timing in bytes of the learned baud rate, and the trim step in percent
`define SCPC_BITS_PER_BYTE 20'd8
`define SCPC_WIN_CONT     4'hf
`define SCPC_CONT_BYTES   20'd32769
`define SCPC_TRIM_STEP    8'sd9
// reset values
`define SCPC_RST_PERIOD   16'h0000
`define SCPC_RST_NIBBLE   4'h0
`endif

// *** design/scpc_pkg.sv ***
// types of the single-pin command interpreter
package scpc_pkg;
    typedef enum logic [7:0] {
        ST_LEARN = 8'h01,
        ST_IDLE  = 8'h02,
        ST_RX    = 8'h04,
        ST_TX    = 8'h08,
        ST_PRE   = 8'h10,
        ST_ANA   = 8'h20,
        ST_POST  = 8'h40,
        ST_FLOAT = 8'h80
    } scpc_state_e;

    typedef struct packed {
        logic        load;
        logic [3:0]  sel;
        logic [15:0] data;
    } scpc_cal_req_s;

    typedef struct packed {
        logic       write;
        logic       erase_all;
        logic       page_clear;
        logic [9:0] addr;
        logic [7:0] data;
    } scpc_ee_req_s;
endpackage

// *** design/scpc_top.sv ***
// single-pin serial command interpreter with timed analog output window
//
// Contract
// [R1] trim code is signed nine percent steps
// [R2] analog window counted in learned byte times
// [R3] window end disconnects analog, output floats
// [R4] commands accepted one byte after window end
// [R5] data pin floats while analog driven; in continuous mode a 59 readback still drives it with analog on
// [R6] host floats line when pins joined
// [R7] code all ones: continuous, 32769 byte float
// [R8] host uses continuous mode on separate pins
// [R9] FF reinitialises, 01 relearns baud rate
// [R10] host power-cycles when link is lost
// [R11] 59 sends byte chosen by pointer
// [R12] pointer 10 to 15 returns CA
// [R13] pointer 7 returns temperature index
// [R14] 69 floats pin, connects analog select
// [R15] value upper nibble, location lower nibble
// [R16] locations 6,7,8 load select, address, pointer
// [R17] location B select, location A window
// [R18] 09 copies data word into calibration register
// [R19] 79 clears page in address bits 3:0
// [R20] 19 writes low data byte to EEPROM
// [R21] locations keep contents between commands
// [R22] index 40 entries at 280 and 281
// [R23] window lasts two to code plus one
// [R24] control code selects the eight actions
// [R25] pointer selects the returned byte
// [R26] start, eight bits lsb first, stop
`timescale 1ns/100ps
`include "scpc_map.svh"
module scpc_top (
    input  wire logic                   CLK_IN,
    input  wire logic                   RESET_N_IN,
    input  wire logic                   SDIO_IN,
    output logic                        SDIO_OUT,
    output logic                        SDIO_OE_OUT,
    output logic                        ANA_EN_OUT,
    output logic [3:0]                  ANA_SEL_OUT,
    input  wire logic [2:0]             TRIM_CODE_IN,
    output logic signed [7:0]           TRIM_PCT_OUT,
    input  wire logic [7:0]             TEMP_INDEX_IN,
    input  wire logic [7:0]             EE_RDATA_IN,
    input  wire logic [15:0]            CAL_RDATA_IN,
    output scpc_pkg::scpc_cal_req_s     CAL_REQ_OUT,
    output scpc_pkg::scpc_ee_req_s      EE_REQ_OUT
);
    import scpc_pkg::*;

    // two's-complement trim code times the step size
    function automatic logic signed [7:0] trim_pct(input logic [2:0] c);
        trim_pct = 8'(signed'({{5{c[2]}}, c}) * `SCPC_TRIM_STEP);  // R1
    endfunction

    // window length in bit times: (2^code + 1) bytes
    function automatic logic [19:0] win_bits(input logic [3:0] c);
        win_bits = 20'((20'd1 << c) + 20'd1) * `SCPC_BITS_PER_BYTE;  // R23
    endfunction

    // pin synchroniser and edge detect
    logic       sync1_q, sync2_q, line_q;
    logic       fall;
    assign fall = line_q & ~sync2_q;

    scpc_state_e  st_q, st_d;
    logic [15:0]  period_q;        // learned oscillator cycles per bit
    logic [15:0]  cyc_q;           // cycle counter inside one bit
    logic [19:0]  bits_q;          // remaining bit times of a timed state
    logic [3:0]   idx_q;           // bit index of rx/tx frame
    logic [7:0]   rx_q;
    logic [10:0]  tx_q;
    logic         cont_q;          // continuous analog mode active
    logic [15:0]  dhr_q;
    logic [3:0]   cal_sel_q, ptr_q, win_q, asel_q, ctrl_q;
    logic [9:0]   ee_q;
    logic         bit_tick;
    assign bit_tick = (cyc_q == 16'h0000);

    // incoming byte split into value and location
    // last data bit joins straight from the synchroniser at the final sample
    logic [7:0] rx_byte;
    logic [3:0] val, loc;
    assign rx_byte = {sync2_q, rx_q[7:1]};  // R26
    assign val = rx_byte[7:4];  // R15
    assign loc = rx_byte[3:0];  // R15
    logic       rx_done, is_reinit, is_ctrl;
    assign rx_done   = (st_q == ST_RX) & bit_tick & (idx_q == 4'h8);
    assign is_reinit = (rx_byte == `SCPC_BYTE_REINIT);
    assign is_ctrl   = (loc == `SCPC_LOC_CTRL) & ~is_reinit;

    // readback byte selection
    logic [7:0] rb_byte;
    assign rb_byte =
        (ptr_q == `SCPC_RP_DLO)     ? dhr_q[7:0] :                 // R25
        (ptr_q == `SCPC_RP_DHI)     ? dhr_q[15:8] :                // R25
        (ptr_q == `SCPC_RP_EECAL)   ? {ee_q[7:4], cal_sel_q} :
        (ptr_q == `SCPC_RP_CTRLPTR) ? {ctrl_q, ptr_q} :
        (ptr_q == `SCPC_RP_ANA)     ? {asel_q, win_q} :
        (ptr_q == `SCPC_RP_EEADDR)  ? ee_q[7:0] :                  // R25
        (ptr_q == `SCPC_RP_EEDATA)  ? EE_RDATA_IN :                // R25
        (ptr_q == `SCPC_RP_TEMP)    ? TEMP_INDEX_IN :              // R13
        (ptr_q == `SCPC_RP_BITCLK)  ? (|period_q[15:8] ? 8'hff : period_q[7:0]) :
        (ptr_q >= `SCPC_RP_FIRSTCA) ? `SCPC_BYTE_LINK : 8'h00;     // R12

    // action decode of a finished command byte
    logic do_read, do_ana;
    assign do_read = is_ctrl & (val == `SCPC_CC_READBACK);  // R11
    assign do_ana  = is_ctrl & (val == `SCPC_CC_ANALOG);    // R14

    // next state
    always_comb begin
        st_d = st_q;
        case (st_q)
            ST_LEARN: st_d = (~sync2_q & line_q) ? ST_LEARN : st_q;
            ST_IDLE:  st_d = fall ? ST_RX : ST_IDLE;
            ST_RX: begin
                if (rx_done) begin
                    if (is_reinit)
                        st_d = ST_LEARN;                     // R9
                    else if (do_read)
                        st_d = ST_TX;                        // R11
                    else if (do_ana && win_q != `SCPC_WIN_CONT)
                        st_d = ST_PRE;                       // R14
                    else if (cont_q || do_ana)
                        st_d = ST_FLOAT;                     // R7
                    else
                        st_d = ST_POST;
                end
            end
            ST_TX:    st_d = (bit_tick && idx_q == 4'ha) ? (cont_q ? ST_FLOAT : ST_POST) : ST_TX;
            ST_PRE:   st_d = (bit_tick && bits_q == 20'd1) ? ST_ANA : ST_PRE;
            ST_ANA:   st_d = (bit_tick && bits_q == 20'd1) ? ST_POST : ST_ANA;   // R3
            ST_POST:  st_d = (bit_tick && bits_q == 20'd1) ? ST_IDLE : ST_POST;  // R4
            ST_FLOAT: st_d = (bit_tick && bits_q == 20'd1) ? ST_IDLE : ST_FLOAT; // R7
            default:  st_d = ST_LEARN;
        endcase
    end

    // learning: first low pulse of 01 is one bit time; last clock of it ends here
    logic learn_end;
    assign learn_end = (st_q == ST_LEARN) & ~line_q & sync2_q;

    // synchroniser, state and timers
    always_ff @(posedge CLK_IN) begin
        if (!RESET_N_IN) begin
            sync1_q  <= 1'b1;
            sync2_q  <= 1'b1;
            line_q   <= 1'b1;
            st_q     <= ST_LEARN;
            period_q <= `SCPC_RST_PERIOD;
            cyc_q    <= 16'h0000;
            bits_q   <= 20'd0;
            idx_q    <= 4'h0;
        end else begin
            sync1_q <= SDIO_IN;
            sync2_q <= sync1_q;
            line_q  <= sync2_q;
            st_q    <= (learn_end && period_q != 16'h0000) ? ST_POST : st_d;
            idx_q   <= (st_q != st_d) ? 4'h0 : idx_q + 4'(bit_tick);
            // learn period from the width of the first low pulse  R9
            if (st_q == ST_LEARN) begin
                if (fall)
                    period_q <= 16'h0001;
                else if (~sync2_q && period_q != 16'h0000 && period_q != 16'hffff)
                    period_q <= period_q + 16'h0001;
            end
            // bit clock: rx starts at mid start bit, others on whole bits  R26
            if (st_q == ST_IDLE && fall)
                cyc_q <= period_q >> 1;
            else if (st_q != st_d || learn_end || bit_tick)
                cyc_q <= period_q - 16'h0001;
            else
                cyc_q <= cyc_q - 16'h0001;
            // timed states counted in bit times of the learned rate  R2
            if (learn_end || (st_q != ST_POST && st_d == ST_POST) || st_d == ST_PRE && st_q != ST_PRE)
                bits_q <= `SCPC_BITS_PER_BYTE;               // R4
            else if (st_q == ST_PRE && st_d == ST_ANA)
                bits_q <= win_bits(win_q);                   // R23
            else if (st_q != ST_FLOAT && st_d == ST_FLOAT)
                bits_q <= `SCPC_CONT_BYTES * `SCPC_BITS_PER_BYTE;  // R7
            else if (bit_tick && bits_q != 20'd0)
                bits_q <= bits_q - 20'd1;
        end
    end

    // receive shift register, lsb first  R26
    always_ff @(posedge CLK_IN) begin
        if (!RESET_N_IN)
            rx_q <= 8'h00;
        else if (st_q == ST_RX && bit_tick && idx_q != 4'h0 && idx_q <= 4'h8)
            rx_q <= {sync2_q, rx_q[7:1]};
        else if (st_q == ST_RX && bit_tick && idx_q == 4'h0)
            rx_q <= {sync2_q, rx_q[7:1]};
    end

    // interface locations, kept until rewritten  R21
    always_ff @(posedge CLK_IN) begin
        if (!RESET_N_IN) begin
            dhr_q     <= 16'h0000;
            cal_sel_q <= `SCPC_RST_NIBBLE;
            ptr_q     <= `SCPC_RST_NIBBLE;
            win_q     <= `SCPC_RST_NIBBLE;
            asel_q    <= `SCPC_RST_NIBBLE;
            ctrl_q    <= `SCPC_RST_NIBBLE;
            ee_q      <= 10'h000;
        end else if (rx_done && !is_reinit) begin
            case (loc)
                `SCPC_LOC_DHR0:   dhr_q[3:0]   <= val;       // R15
                `SCPC_LOC_DHR1:   dhr_q[7:4]   <= val;       // R15
                `SCPC_LOC_DHR2:   dhr_q[11:8]  <= val;       // R15
                `SCPC_LOC_DHR3:   dhr_q[15:12] <= val;       // R15
                `SCPC_LOC_CALSEL: begin
                    cal_sel_q  <= val;                       // R16
                    ee_q[3:0]  <= val;                       // R16
                end
                `SCPC_LOC_EEMID:  ee_q[7:4] <= val;          // R16
                `SCPC_LOC_EEHI: begin
                    ee_q[9:8] <= val[1:0];                   // R16
                    ptr_q     <= val;                        // R16
                end
                `SCPC_LOC_WIN:    win_q  <= val;             // R17
                `SCPC_LOC_ASEL:   asel_q <= val;             // R17
                `SCPC_LOC_CTRL: begin
                    ctrl_q <= val;                           // R24
                    if (val == `SCPC_CC_CALREAD)
                        dhr_q <= CAL_RDATA_IN;               // R24
                    else if (val == `SCPC_CC_EEREAD)
                        dhr_q[7:0] <= EE_RDATA_IN;           // R24
                end
                default: ;
            endcase
        end
    end

    // control actions as one-cycle requests
    always_ff @(posedge CLK_IN) begin
        if (!RESET_N_IN) begin
            CAL_REQ_OUT <= '0;
            EE_REQ_OUT  <= '0;
        end else begin
            CAL_REQ_OUT.load <= rx_done & is_ctrl & (val == `SCPC_CC_CALLOAD);        // R18
            CAL_REQ_OUT.sel  <= cal_sel_q;                                              // R18
            CAL_REQ_OUT.data <= dhr_q;                                                  // R18
            EE_REQ_OUT.write      <= rx_done & is_ctrl & (val == `SCPC_CC_EEWRITE);    // R20
            EE_REQ_OUT.erase_all  <= rx_done & is_ctrl & (val == `SCPC_CC_ERASE);      // R24
            EE_REQ_OUT.page_clear <= rx_done & is_ctrl & (val == `SCPC_CC_PAGECLR);    // R19
            EE_REQ_OUT.addr       <= ee_q;                                              // R22
            EE_REQ_OUT.data       <= dhr_q[7:0];                                        // R20
        end
    end

    // readback frame: one idle bit, start, eight data, stop  R11
    always_ff @(posedge CLK_IN) begin
        if (!RESET_N_IN)
            tx_q <= 11'h7ff;
        else if (rx_done && do_read)
            tx_q <= {1'b1, rb_byte, 1'b0, 1'b1};
        else if (st_q == ST_TX && bit_tick)
            tx_q <= {1'b1, tx_q[10:1]};
    end

    // pin and analog drive, all from flip-flops
    always_ff @(posedge CLK_IN) begin
        if (!RESET_N_IN) begin
            SDIO_OUT     <= 1'b1;
            SDIO_OE_OUT  <= 1'b0;
            ANA_EN_OUT   <= 1'b0;
            ANA_SEL_OUT  <= `SCPC_RST_NIBBLE;
            cont_q       <= 1'b0;
            TRIM_PCT_OUT <= 8'sd0;
        end else begin
            SDIO_OUT     <= tx_q[0];
            SDIO_OE_OUT  <= (st_d == ST_TX) & (st_q == ST_TX) & (idx_q != 4'h0);  // R5
            TRIM_PCT_OUT <= trim_pct(TRIM_CODE_IN);                               // R1
            if (st_d == ST_LEARN)
                cont_q <= 1'b0;
            else if (rx_done && do_ana)
                cont_q <= (win_q == `SCPC_WIN_CONT);                              // R7
            ANA_EN_OUT  <= (st_d == ST_ANA) | (cont_q & st_d != ST_LEARN)
                           | (rx_done & do_ana & win_q == `SCPC_WIN_CONT);       // R3
            if (rx_done && do_ana)
                ANA_SEL_OUT <= asel_q;                                            // R14
        end
    end
endmodule

// *** test/scpc_monitor.sv ***
// port checker of the single-pin command interpreter
`timescale 1ns/100ps
module scpc_monitor (
    input wire logic                   CLK_IN,
    input wire logic                   RESET_N_IN,
    input wire logic                   SDIO_OUT,
    input wire logic                   SDIO_OE_OUT,
    input wire logic                   ANA_EN_OUT,
    input wire logic [2:0]             TRIM_CODE_IN,
    input wire logic signed [7:0]      TRIM_PCT_OUT,
    input wire scpc_pkg::scpc_cal_req_s CAL_REQ_OUT,
    input wire scpc_pkg::scpc_ee_req_s  EE_REQ_OUT
);
    import scpc_pkg::*;
    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (!RESET_N_IN);
    logic signed [7:0] trim_exp;
    logic              ee_pulse;
    // expected trim percent and any eeprom strobe
    assign trim_exp = $signed({{5{TRIM_CODE_IN[2]}}, TRIM_CODE_IN}) * 8'sd9;
    assign ee_pulse = EE_REQ_OUT.write | EE_REQ_OUT.erase_all | EE_REQ_OUT.page_clear;
    // window end, then a quiet guard on the data pin
    sequence s_win_end; $fell(ANA_EN_OUT); endsequence
    sequence s_quiet; (!SDIO_OE_OUT && !ANA_EN_OUT) [*8]; endsequence
    property p_ana_float; ANA_EN_OUT |-> !SDIO_OE_OUT; endproperty
    a_ana_float: assert property (p_ana_float) else $error("pin driven in window");
    property p_trim; $past(RESET_N_IN) |-> TRIM_PCT_OUT == $past(trim_exp); endproperty
    a_trim: assert property (p_trim) else $error("trim percent wrong");
    property p_start; $rose(SDIO_OE_OUT) |-> !SDIO_OUT; endproperty
    a_start: assert property (p_start) else $error("no start bit");
    property p_stop; $fell(SDIO_OE_OUT) |-> $past(SDIO_OUT); endproperty
    a_stop: assert property (p_stop) else $error("no stop bit");
    property p_cal_pulse; CAL_REQ_OUT.load |=> !CAL_REQ_OUT.load; endproperty
    a_cal_pulse: assert property (p_cal_pulse) else $error("load not one cycle");
    property p_ee_pulse; ee_pulse |=> !ee_pulse; endproperty
    a_ee_pulse: assert property (p_ee_pulse) else $error("eeprom strobe long");
    property p_post_quiet; s_win_end |-> s_quiet; endproperty
    a_post_quiet: assert property (p_post_quiet) else $error("guard too short");
    property p_tx_no_req; SDIO_OE_OUT |-> !CAL_REQ_OUT.load && !ee_pulse; endproperty
    a_tx_no_req: assert property (p_tx_no_req) else $error("request during send");
endmodule
bind scpc_top scpc_monitor i_mon (.CLK_IN, .RESET_N_IN, .SDIO_OUT, .SDIO_OE_OUT,
    .ANA_EN_OUT, .TRIM_CODE_IN, .TRIM_PCT_OUT, .CAL_REQ_OUT, .EE_REQ_OUT);

// *** test/scpc_host.sv ***
// host test computer model on the serial data line
`timescale 1ns/100ps
module scpc_host (
    input  wire logic       clk_in,
    input  wire logic       line_in,
    input  wire logic [7:0] bit_clks_in,
    output logic            drv_out,
    output logic            oe_out
);
    // released at start, pull-up holds the line high
    initial begin
        drv_out = 1'b1;
        oe_out = 1'b0;
    end
    // frame lsb first; gap 0 releases at mid stop bit for a reply
    task automatic send_byte(input logic [7:0] b, input int gap);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        @(negedge clk_in);
        oe_out = 1'b1;
        for (int i = 0; i < 10; i++) begin
            drv_out = f[i];
            repeat ((i == 9 && gap == 0) ? bit_clks_in / 2 : bit_clks_in) @(negedge clk_in);
        end
        oe_out = 1'b0;
        repeat (gap * bit_clks_in) @(negedge clk_in);
    endtask
    // wait up to a byte time for a start bit, sample mid bit
    task automatic recv_byte(output logic [7:0] b, output logic ok);
        int n;
        n = 0;
        while (line_in !== 1'b0 && n < 8 * bit_clks_in) begin
            @(negedge clk_in);
            n++;
        end
        ok = (line_in === 1'b0);
        repeat (bit_clks_in / 2) @(negedge clk_in);
        for (int i = 0; i < 8; i++) begin
            repeat (bit_clks_in) @(negedge clk_in);
            b[i] = line_in;
        end
        repeat (10 * bit_clks_in) @(negedge clk_in);
    endtask
endmodule

// *** test/tb_scpc_top.sv ***
// self-checking bench of the single-pin command interpreter
`timescale 1ns/100ps
module tb_scpc_top;
    import scpc_pkg::*;
    logic              CLK_IN, RESET_N_IN, host_drv, host_oe, sdio_line, sdio_out;
    logic              sdio_oe, ana_en, ok;
    logic [3:0]        ana_sel;
    logic [2:0]        trim_code;
    logic signed [7:0] trim_pct;
    logic [7:0]        temp_idx, ee_rdata, bit_clks, rx;
    logic [15:0]       cal_rdata;
    scpc_cal_req_s     cal_req;
    scpc_cal_req_s     cal_seen = '0;
    scpc_ee_req_s      ee_req;
    scpc_ee_req_s      ee_seen = '0;
    int                error_cnt = 0;
    int                num_checks = 0;
    // line level: device, else host, else pull-up
    assign sdio_line = sdio_oe ? sdio_out : (host_oe ? host_drv : 1'b1);
    scpc_top i_dut (.CLK_IN(CLK_IN), .RESET_N_IN(RESET_N_IN), .SDIO_IN(sdio_line),
        .SDIO_OUT(sdio_out), .SDIO_OE_OUT(sdio_oe), .ANA_EN_OUT(ana_en),
        .ANA_SEL_OUT(ana_sel), .TRIM_CODE_IN(trim_code), .TRIM_PCT_OUT(trim_pct),
        .TEMP_INDEX_IN(temp_idx), .EE_RDATA_IN(ee_rdata), .CAL_RDATA_IN(cal_rdata),
        .CAL_REQ_OUT(cal_req), .EE_REQ_OUT(ee_req));
    scpc_host u_host (.clk_in(CLK_IN), .line_in(sdio_line), .bit_clks_in(bit_clks),
        .drv_out(host_drv), .oe_out(host_oe));
    // clock
    initial begin
        CLK_IN = 1'b0;
        forever #4 CLK_IN = ~CLK_IN;
    end
    // catch one-cycle request strobes
    always @(posedge CLK_IN) begin
        if (cal_req.load)
            cal_seen <= cal_req;
        if (ee_req.write | ee_req.erase_all | ee_req.page_clear)
            ee_seen <= ee_req;
    end
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic cmd(input logic [7:0] b);
        u_host.send_byte(b, 10);
    endtask
    // load pointer, send readback, compare reply
    task automatic rb(input logic [3:0] p, input logic [7:0] exp);
        cmd({p, 4'h8});
        u_host.send_byte(8'h59, 0);
        u_host.recv_byte(rx, ok);
        check(ok, 1'b1);
        check(rx, exp);
    endtask
    task automatic t_trim;
        logic [7:0] tbl [8] = '{8'h00, 8'h09, 8'h12, 8'h1b, 8'hdc, 8'he5, 8'hee, 8'hf7};
        for (int c = 0; c < 8; c++) begin
            trim_code = 3'(c);
            repeat (2) @(negedge CLK_IN);
            check($unsigned(trim_pct), tbl[c]);
        end
    endtask
    task automatic t_link;
        temp_idx = 8'h5a;
        rb(4'hf, 8'hca);
        rb(4'ha, 8'hca);
        rb(4'h7, 8'h5a);
        rb(4'h8, bit_clks);
    endtask
    task automatic t_cal;
        logic [7:0] s [6] = '{8'h00, 8'h41, 8'hc2, 8'h83, 8'h36, 8'h09};
        foreach (s[i]) cmd(s[i]);
        check(32'(cal_seen), 32'h00138c40);
        rb(4'h0, 8'h40);
        rb(4'h1, 8'h8c);
        cal_rdata = 16'h1234;
        cmd(8'h39);
        rb(4'h1, 8'h12);
    endtask
    task automatic t_ee;
        logic [7:0] s [6] = '{8'h06, 8'h87, 8'h28, 8'h00, 8'h41, 8'h19};
        logic [7:0] t [4] = '{8'h16, 8'hc0, 8'h81, 8'h19};
        cmd(8'ha6);
        cmd(8'h79);
        check({ee_seen.page_clear, ee_seen.addr[3:0]}, 5'h1a);
        repeat (2000) @(negedge CLK_IN);
        foreach (s[i]) cmd(s[i]);
        check({ee_seen.write, ee_seen.addr, ee_seen.data}, {1'b1, 10'h280, 8'h40});
        foreach (t[i]) cmd(t[i]);
        check({ee_seen.write, ee_seen.addr, ee_seen.data}, {1'b1, 10'h281, 8'h8c});
        cmd(8'h29);
        check(ee_seen.erase_all, 1'b1);
        repeat (2000) @(negedge CLK_IN);
        ee_rdata = 8'h3c;
        cmd(8'h49);
        rb(4'h0, 8'h3c);
        rb(4'h6, 8'h3c);
        rb(4'h5, 8'h81);
    endtask
    task automatic t_analog;
        int n;
        cmd(8'h1b);
        for (int c = 0; c < 3; c++) begin
            cmd({4'(c), 4'ha});
            u_host.send_byte(8'h69, 0);
            n = 0;
            while (ana_en !== 1'b1 && n < 4000) begin
                @(negedge CLK_IN);
                n++;
            end
            if (n >= 4000) begin
                error_cnt++;
                $display("unexpected at %0t: analog window never opened", $time);
                final_report();
            end
            n = 0;
            while (ana_en === 1'b1 && n < 20000) begin
                @(negedge CLK_IN);
                n++;
            end
            check(n, ((1 << c) + 1) * 8 * bit_clks);
            check(ana_sel, 4'h1);
            repeat (10 * bit_clks) @(negedge CLK_IN);
        end
        rb(4'hf, 8'hca);
    endtask
    task automatic t_rebaud;
        cmd(8'hff);
        bit_clks = 8'd24;
        cmd(8'h01);
        rb(4'hf, 8'hca);
        rb(4'h8, 8'd24);
    endtask
    // continuous window on a separate analog pin, line ignored, reset relearns
    task automatic t_cont;
        cmd(8'hfa);
        u_host.send_byte(8'h69, 10);
        check(ana_en, 1'b1);
        cmd(8'hf8);
        u_host.send_byte(8'h59, 0);
        u_host.recv_byte(rx, ok);
        check(ok, 1'b0);
        check(ana_en, 1'b1);
        RESET_N_IN = 1'b0;
        repeat (2) @(negedge CLK_IN);
        RESET_N_IN = 1'b1;
        repeat (4) @(negedge CLK_IN);
        check(ana_en, 1'b0);
        cmd(8'h01);
        rb(4'h8, bit_clks);
    endtask
    // reset, learn rate, then scenarios
    initial begin
        RESET_N_IN = 1'b0;
        {trim_code, temp_idx, ee_rdata, cal_rdata} = '0;
        bit_clks = 8'd16;
        repeat (2) @(negedge CLK_IN);
        RESET_N_IN = 1'b1;
        repeat (4) @(negedge CLK_IN);
        cmd(8'h01);
        t_trim();
        t_link();
        t_cal();
        t_ee();
        t_analog();
        t_rebaud();
        t_cont();
        final_report();
    end
endmodule
